// *** logic/umpm_top.sv ***
// Modem-control pins, multi-function output and reset behaviour of one
// UART channel, with registers on a classic Wishbone slave.
// Assumes a serial engine in the same sys_clk domain that supplies raw
// transmit data, load and done pulses and the 16x baud clock.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module umpm_top
	import umpm_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Serial engine side
	input  wire logic        engine_tx_data,
	input  wire logic        engine_tx_load,
	input  wire logic        engine_tx_done,
	input  wire logic        engine_rx_above_trigger,
	input  wire logic        engine_rx_ready,
	input  wire logic        engine_baud16,
	output logic             engine_rx_data,
	output logic             engine_tx_allowed,
	// Pins
	input  wire logic        rx_in,
	input  wire logic        clear_to_send_in,
	input  wire logic        set_ready_in,
	input  wire logic        carrier_detect_in,
	input  wire logic        ring_indicator_in,
	output logic             tx_out,
	output logic             request_to_send_out,
	output logic             terminal_ready_out,
	output logic             multi_function_out
);
	import umpm_pkg::*;

	typedef struct packed
	{
		logic [7:0]  modem_control_reg;
		logic [7:0]  alternate_function_control;
		logic [7:0]  enhanced_feature_control;
		logic [7:0]  feature_control_reg;
		logic [7:0]  interrupt_enable_reg;
		umpm_dir_t   dir;
		logic        cts_prev;
		logic        cts_event;
		logic        ack;
		logic [31:0] rdata;
		logic        tx;
		logic        rts;
		logic        dtr;
		logic        tx_allowed;
		logic        rx;
	} umpm_state_t;

	localparam umpm_state_t STATE_RESET = '{
		modem_control_reg:          REG_RESET,
		alternate_function_control: REG_RESET,
		enhanced_feature_control:   REG_RESET,
		feature_control_reg:        REG_RESET,
		interrupt_enable_reg:       REG_RESET,
		dir:                        DIR_RECEIVE,
		cts_prev:                   1'b1,
		cts_event:                  1'b0,
		ack:                        1'b0,
		rdata:                      RD_ZERO,
		tx:                         1'b1,
		rts:                        1'b1,
		dtr:                        1'b1,
		tx_allowed:                 1'b0,
		rx:                         1'b1
	};

	umpm_state_t  cur;
	umpm_state_t  next_cur;
	umpm_mf_sel_t mf_sel;

	// Byte lane 0 write strobe for a given address
	function automatic logic lane0_write(input logic [4:0] addr,
		input logic [4:0] target);
		lane0_write = wb_cyc_i && wb_stb_i && wb_we_i && !cur.ack
			&& wb_sel_i[0] && (addr == target);
	endfunction

	// Extend a byte to a bus word
	function automatic logic [31:0] word_of(input logic [7:0] b);
		word_of = {24'h00_0000, b};
	endfunction

	logic bus_req;
	logic [7:0] pin_status;
	logic       tx_idle_level;

	always_comb
	begin
		next_cur = cur;
		bus_req = wb_cyc_i && wb_stb_i && !cur.ack;

		// Status only; apart from clear-to-send, these pins steer nothing else
		pin_status = 8'h00;
		pin_status[STS_CTS_BIT] = ~clear_to_send_in;
		pin_status[STS_DSR_BIT] = ~set_ready_in;
		pin_status[STS_CD_BIT]  = ~carrier_detect_in;
		pin_status[STS_RI_BIT]  = ~ring_indicator_in;
		pin_status[STS_DIR_BIT] = (cur.dir == DIR_TRANSMIT);
		pin_status[STS_CEV_BIT] = cur.cts_event;

		// Bus answer one cycle after the request, dropped the next cycle
		next_cur.ack = bus_req;
		next_cur.rdata = RD_ZERO;
		if (bus_req && !wb_we_i)
		begin
			case (wb_adr_i)
				ADDR_MODEM_CTRL:
					next_cur.rdata = word_of(cur.modem_control_reg);
				ADDR_ALT_FUNC:
					next_cur.rdata = word_of(cur.alternate_function_control);
				ADDR_ENH_FEAT:
					next_cur.rdata = word_of(cur.enhanced_feature_control);
				ADDR_FEAT_CTRL:
					next_cur.rdata = word_of(cur.feature_control_reg);
				ADDR_INT_ENABLE:
					next_cur.rdata = word_of(cur.interrupt_enable_reg);
				ADDR_PIN_STATUS:
					next_cur.rdata = word_of(pin_status);
				default:
					next_cur.rdata = RD_ZERO;
			endcase
		end

		if (lane0_write(wb_adr_i, ADDR_MODEM_CTRL))
			next_cur.modem_control_reg = wb_dat_i[7:0];
		if (lane0_write(wb_adr_i, ADDR_ALT_FUNC))
			next_cur.alternate_function_control = wb_dat_i[7:0];
		if (lane0_write(wb_adr_i, ADDR_ENH_FEAT))
			next_cur.enhanced_feature_control = wb_dat_i[7:0];
		if (lane0_write(wb_adr_i, ADDR_FEAT_CTRL))
			next_cur.feature_control_reg = wb_dat_i[7:0];
		if (lane0_write(wb_adr_i, ADDR_INT_ENABLE))
			next_cur.interrupt_enable_reg = wb_dat_i[7:0];

		// Clear-to-send change event, write one to clear; set wins
		next_cur.cts_prev = clear_to_send_in;
		if (lane0_write(wb_adr_i, ADDR_PIN_STATUS)
			&& wb_dat_i[STS_CEV_BIT])
			next_cur.cts_event = 1'b0;
		if (cur.interrupt_enable_reg[IER_CTS_BIT]
			&& cur.enhanced_feature_control[EFR_ACTS_BIT]
			&& (clear_to_send_in != cur.cts_prev))
			next_cur.cts_event = 1'b1;

		// Auto transmit gate from clear-to-send
		if (cur.enhanced_feature_control[EFR_ACTS_BIT])
			next_cur.tx_allowed = ~clear_to_send_in;
		else
			next_cur.tx_allowed = 1'b1;

		// Half-duplex direction tracking
		case (cur.dir)
			DIR_RECEIVE:
				if (engine_tx_load)
					next_cur.dir = DIR_TRANSMIT;
			DIR_TRANSMIT:
				if (engine_tx_done && !engine_tx_load)
					next_cur.dir = DIR_RECEIVE;
			default:
				next_cur.dir = DIR_RECEIVE;
		endcase

		// Request-to-send pin source
		if (cur.feature_control_reg[FEATURE_CONTROL_REG_DIR_BIT])
			next_cur.rts = (cur.dir != DIR_TRANSMIT);
		else if (cur.enhanced_feature_control[EFR_ARTS_BIT])
			// Software has set the request bit first
			next_cur.rts = ~(cur.modem_control_reg[MCR_RTS_BIT]
				&& !engine_rx_above_trigger);
		else
			next_cur.rts = ~cur.modem_control_reg[MCR_RTS_BIT];

		next_cur.dtr = ~cur.modem_control_reg[MCR_DTR_BIT];

		// Infrared mode idles low, normal mode idles high
		tx_idle_level = ~cur.modem_control_reg[MCR_IR_BIT];
		if (cur.dir == DIR_TRANSMIT || engine_tx_load)
			next_cur.tx = engine_tx_data;
		else
			next_cur.tx = tx_idle_level;

		next_cur.rx = rx_in;
	end

	// Reset holds outputs idle and blocks the receive input
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cur <= STATE_RESET;
		else
			cur <= next_cur;
	end

	assign mf_sel = umpm_mf_sel_t'(
		cur.alternate_function_control[AFR_SEL_HI:AFR_SEL_LO]);

	umpm_mf_mux u_mf_mux
	(
		.sys_clk                 (sys_clk),
		.sys_rst                 (sys_rst),
		.mf_sel                  (mf_sel),
		.general_purpose_out_two (cur.modem_control_reg[MCR_OP2_BIT]),
		.baud_clock_in           (engine_baud16),
		.rx_data_ready           (engine_rx_ready),
		.multi_function_out      (multi_function_out)
	);

	assign wb_dat_o            = cur.rdata;
	assign wb_ack_o            = cur.ack;
	assign tx_out              = cur.tx;
	assign request_to_send_out = cur.rts;
	assign terminal_ready_out  = cur.dtr;
	assign engine_tx_allowed   = cur.tx_allowed;
	assign engine_rx_data      = cur.rx;

endmodule

// *** shared/umpm_pkg.sv ***
// Constants, register map and types for the modem pin and multi-function
// output block. Shared by the top module and the output mux.
package umpm_pkg;

	// Wishbone register byte addresses
	localparam logic [4:0] ADDR_MODEM_CTRL  = 5'h00;
	localparam logic [4:0] ADDR_ALT_FUNC    = 5'h04;
	localparam logic [4:0] ADDR_ENH_FEAT    = 5'h08;
	localparam logic [4:0] ADDR_FEAT_CTRL   = 5'h0c;
	localparam logic [4:0] ADDR_INT_ENABLE  = 5'h10;
	localparam logic [4:0] ADDR_PIN_STATUS  = 5'h14;

	// Modem control fields
	localparam int MCR_DTR_BIT  = 0;
	localparam int MCR_RTS_BIT  = 1;
	localparam int MCR_OP2_BIT  = 3;
	localparam int MCR_IR_BIT   = 6;
	// Alternate function select field
	localparam int AFR_SEL_LO   = 1;
	localparam int AFR_SEL_HI   = 2;
	// Enhanced feature fields
	localparam int EFR_ARTS_BIT = 6;
	localparam int EFR_ACTS_BIT = 7;
	// Feature control field
	localparam int FEATURE_CONTROL_REG_DIR_BIT = 3;
	// Interrupt enable field
	localparam int IER_CTS_BIT  = 7;
	// Pin status fields
	localparam int STS_CTS_BIT  = 0;
	localparam int STS_DSR_BIT  = 1;
	localparam int STS_CD_BIT   = 2;
	localparam int STS_RI_BIT   = 3;
	localparam int STS_DIR_BIT  = 4;
	localparam int STS_CEV_BIT  = 5;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	// Reset pulse width
	localparam int CLK_PERIOD_PS  = 25000;
	localparam int RESET_MIN_PS   = 40000;
	localparam int RESET_MIN_CYC  =
		(RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Multi-function output selection
	typedef enum logic [1:0]
	{
		MF_GP_OUT   = 2'h0,
		MF_BAUD_CLK = 2'h1,
		MF_RX_READY = 2'h2,
		MF_RESERVED = 2'h3
	} umpm_mf_sel_t;

	// Half-duplex direction states
	typedef enum logic [1:0]
	{
		DIR_RECEIVE  = 2'h1,
		DIR_TRANSMIT = 2'h2
	} umpm_dir_t;

endpackage

// *** logic/umpm_mf_mux.sv ***
// Registered selector for the multi-function output pin.
// Assumes sys_clk domain inputs and an asynchronous active-high reset.
`timescale 1ns/1ps
module umpm_mf_mux
	import umpm_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire umpm_mf_sel_t mf_sel,
	input  wire logic         general_purpose_out_two,
	input  wire logic         baud_clock_in,
	input  wire logic         rx_data_ready,
	output logic              multi_function_out
);
	import umpm_pkg::*;

	typedef struct packed
	{
		logic pin;
	} umpm_mux_state_t;

	umpm_mux_state_t cur;
	umpm_mux_state_t next_cur;

	always_comb
	begin
		next_cur = cur;
		case (mf_sel)
			MF_GP_OUT:   next_cur.pin = ~general_purpose_out_two;
			MF_BAUD_CLK: next_cur.pin = baud_clock_in;
			MF_RX_READY: next_cur.pin = ~rx_data_ready;
			default:     next_cur.pin = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cur <= '{pin: 1'b1};
		else
			cur <= next_cur;
	end

	assign multi_function_out = cur.pin;

endmodule

// *** dv/umpm_properties.sv ***
// Concurrent checks on the modem pin block's ports.
// Assumes binding to umpm_top; ports match by name.
`timescale 1ns/1ps
module umpm_checker
	import umpm_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [4:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        engine_rx_data,
	input wire logic        rx_in,
	input wire logic        tx_out,
	input wire logic        request_to_send_out,
	input wire logic        terminal_ready_out,
	input wire logic        multi_function_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack missing");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == RD_ZERO)
		else $error("idle read data");
	chk_byte_wide: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits");
	chk_dtr_write: assert property (
		wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_MODEM_CTRL
		|=> terminal_ready_out == !$past(wb_dat_i[0]))
		else $error("terminal ready wrong");
	chk_tx_reset: assert property (
		disable iff (1'b0) sys_rst |-> tx_out)
		else $error("tx low in reset");
	chk_rx_ignored: assert property (
		disable iff (1'b0) sys_rst |-> engine_rx_data)
		else $error("rx passed in reset");
	chk_rx_follow: assert property (
		!$past(sys_rst) |-> engine_rx_data == $past(rx_in))
		else $error("rx not passed");
	chk_pins_reset: assert property (
		disable iff (1'b0) sys_rst |-> request_to_send_out
		&& terminal_ready_out && multi_function_out)
		else $error("pins not reset");
endmodule

// *** dv/umpm_line_model.sv ***
// Far side model: modem lines and receive data, all active low.
// Assumes the bench names which lines are asserted.
`timescale 1ns/1ps
module umpm_line_model
(
	input  wire logic       sys_clk,
	input  wire logic [3:0] assert_lines,
	output logic            rx_in,
	output logic            clear_to_send_in,
	output logic            set_ready_in,
	output logic            carrier_detect_in,
	output logic            ring_indicator_in
);
	initial {rx_in, clear_to_send_in, set_ready_in, carrier_detect_in,
		ring_indicator_in} = 5'h1f;
	// Receive data keeps toggling, also through reset
	always @(posedge sys_clk)
	begin
		{ring_indicator_in, carrier_detect_in, set_ready_in,
			clear_to_send_in} <= ~assert_lines;
		rx_in <= ~rx_in;
	end
endmodule

// *** dv/umpm_top_tb.sv ***
// Bench for the modem pin block: bus tasks, line model, read monitor.
// Assumes umpm_top, umpm_line_model and umpm_checker compiled first.
`timescale 1ns/1ps
module umpm_top_tb;
	import umpm_pkg::*;
	logic        sys_clk = 0, sys_rst = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic        wb_we_i = 0, wb_ack_o, engine_tx_data = 1;
	logic        engine_tx_load = 0, engine_tx_done = 0, engine_baud16 = 0;
	logic        engine_rx_above_trigger = 0, engine_rx_ready = 0;
	logic        engine_rx_data, engine_tx_allowed, rx_in, tx_out;
	logic        clear_to_send_in, set_ready_in, carrier_detect_in;
	logic        ring_indicator_in, request_to_send_out;
	logic        terminal_ready_out, multi_function_out;
	logic [4:0]  wb_adr_i = 0;
	logic [3:0]  wb_sel_i = 0, assert_lines = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, exp_q[$];
	logic [7:0]  v;
	int          errors = 0, checked = 0, ticks = 0, seed = 42265;

	umpm_top umpm_top_i (.*);
	umpm_line_model umpm_line_model_i (.*);

	always #12.5 sys_clk = ~sys_clk;

	task check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task give_verdict;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i}
			<= {2'b11, w, a, 4'h1, 24'h0, d};
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask

	task rd(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask

	task settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	// Read data is compared when its ack shows
	always @(posedge sys_clk)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check("read", wb_dat_o, exp_q.size() ? exp_q.pop_front() : 'x);

	always @(posedge sys_clk)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			errors++;
			give_verdict();
		end
	end

	initial
	begin
		sys_rst <= 1;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 0;
		for (int a = 0; a < 7; a++)
			rd(5'(a * 4), 8'h00);
		bus(1'b1, 5'h18, 8'hff);
		rd(5'h18, 8'h00);
		settle;
		check("idle pins", {tx_out, request_to_send_out, terminal_ready_out,
			multi_function_out}, 4'hf);
		$display("test reset done");
		for (int s = 0; s < 4; s++)
		begin
			bus(1'b1, ADDR_ALT_FUNC, 8'(s << 1));
			for (int k = 0; k < 2; k++)
			begin
				v = 8'($random(seed));
				@(posedge sys_clk);
				engine_rx_ready <= v[0];
				engine_baud16 <= v[1];
				bus(1'b1, ADDR_MODEM_CTRL, {4'h0, v[3], 3'h0});
				settle;
				check("mf", multi_function_out, s == 0 ? !v[3] : s == 1 ? v[1]
					: s == 2 ? !v[0] : 1'b1);
			end
		end
		$display("test multi function done");
		for (int k = 0; k < 4; k++)
		begin
			v = (8'($random(seed)) & 8'h03) | (k[0] ? 8'h40 : 8'h00);
			bus(1'b1, ADDR_MODEM_CTRL, v);
			settle;
			check("dtr", terminal_ready_out, !v[0]);
			check("rts", request_to_send_out, !v[1]);
			check("tx idle", tx_out, !v[6]);
		end
		$display("test modem outputs done");
		bus(1'b1, ADDR_MODEM_CTRL, 8'h02);
		bus(1'b1, ADDR_ENH_FEAT, 8'h40);
		engine_rx_above_trigger <= 1;
		settle;
		check("auto rts", request_to_send_out, 1'b1);
		bus(1'b1, ADDR_FEAT_CTRL, 8'h08);
		engine_tx_data <= v[0];
		@(posedge sys_clk);
		engine_tx_load <= 1;
		@(posedge sys_clk);
		engine_tx_load <= 0;
		settle;
		check("dir send", request_to_send_out, 1'b0);
		check("tx data", tx_out, v[0]);
		rd(ADDR_PIN_STATUS, 8'h10);
		@(posedge sys_clk);
		engine_tx_done <= 1;
		@(posedge sys_clk);
		engine_tx_done <= 0;
		settle;
		check("dir receive", request_to_send_out, 1'b1);
		$display("test direction done");
		bus(1'b1, ADDR_ENH_FEAT, 8'h80);
		for (int k = 0; k < 2; k++)
		begin
			v = 8'($random(seed));
			@(posedge sys_clk);
			assert_lines <= {v[2:0], k[0]};
			settle;
			check("tx allowed", engine_tx_allowed, k[0]);
			rd(ADDR_PIN_STATUS, {4'h0, v[2:0], k[0]});
		end
		$display("test lines done");
		bus(1'b1, ADDR_INT_ENABLE, 8'h80);
		@(posedge sys_clk);
		assert_lines <= assert_lines ^ 4'h1;
		settle;
		rd(ADDR_PIN_STATUS, {3'h1, 1'b0, v[2:0], 1'b0});
		bus(1'b1, ADDR_PIN_STATUS, 8'h20);
		rd(ADDR_PIN_STATUS, {4'h0, v[2:0], 1'b0});
		$display("test change event done");
		@(posedge sys_clk);
		sys_rst <= 1;
		repeat (2) @(posedge sys_clk);
		#1 check("in reset", {tx_out, engine_rx_data}, 2'b11);
		@(posedge sys_clk);
		sys_rst <= 0;
		rd(ADDR_MODEM_CTRL, 8'h00);
		rd(ADDR_ENH_FEAT, 8'h00);
		settle;
		check("reads left", exp_q.size(), 0);
		$display("test second reset done");
		give_verdict();
	end
endmodule

bind umpm_top umpm_checker umpm_checker_i (.*);
